// file: logic/gpio_pkg.sv
// Shared constants for the general-purpose port block
package gpio_pkg;
  localparam int PORT_CNT = 7;
  localparam int PORT_W = 8;
  localparam int SHORT_W = 5;
  localparam int THIRD_PORT = 2;
  localparam int SIXTH_PORT = 5;
  localparam int SHORT_PORT = 6;
  localparam logic [2:0] PORT_LAST = 3'h6;
  // Register map: port p at p*PORT_STRIDE, registers at the offsets below
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_OUT = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_PULL = 8'h08;
  localparam logic [7:0] OFS_PIN = 8'h0c;
  localparam logic [7:0] CTRL_ADDR = 8'h80;
  localparam logic [7:0] STAT_ADDR = 8'h84;
  // Control bits
  localparam int CTRL_LEGACY = 0;
  localparam int CTRL_JTAG = 1;
  localparam int CTRL_CONV = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;
  // Boundary-scan pins on the sixth port
  localparam int TCK_BIT = 4;
  localparam int TMS_BIT = 5;
  localparam int TDO_BIT = 6;
  localparam int TDI_BIT = 7;
  // Short port under legacy mode
  localparam int STROBE_CNT = 3;
  localparam logic [4:0] SHORT_LEG_RST = 5'h03;
  localparam logic [7:0] SHORT_MASK = 8'h1f;
  // Cycles after power-on release before the enable pin is taken
  localparam logic [1:0] PEN_SETTLE = 2'h3;
endpackage

// file: logic/sync2.sv
// Two-stage synchroniser for pin inputs
module sync2 #(
  parameter int WIDTH = 8,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {WIDTH{RST_VAL}};
      q_o <= {WIDTH{RST_VAL}};
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// file: logic/pin_cell.sv
// One pin's drive, level and pull-up flip-flops with two reset flavours
module pin_cell #(
  parameter logic ALT_OE = 1'b0,
  parameter logic ALT_OUT = 1'b0,
  parameter logic ALT_PU = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_plain_n_i,
  input wire logic rst_alt_n_i,
  input wire logic oe_nxt_i,
  input wire logic out_nxt_i,
  input wire logic pu_nxt_i,
  output logic oe_o,
  output logic out_o,
  output logic pu_o
);
  // Plain reset floats the pin; alternate reset loads the mode's values
  always_ff @(posedge ref_clk_i or negedge rst_plain_n_i or negedge rst_alt_n_i) begin
    if (!rst_plain_n_i) begin
      oe_o <= 1'b0;
      out_o <= 1'b0;
      pu_o <= 1'b0;
    end else if (!rst_alt_n_i) begin
      oe_o <= ALT_OE;
      out_o <= ALT_OUT;
      pu_o <= ALT_PU;
    end else begin
      oe_o <= oe_nxt_i;
      out_o <= out_nxt_i;
      pu_o <= pu_nxt_i;
    end
  end
endmodule

// file: logic/port_pin_reset_behaviour.sv
// General-purpose ports with reset tri-stating and legacy mode, in which the third port and strobe pins drive through reset
module port_pin_reset_behaviour import gpio_pkg::*; (
  // Clock and resets
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic por_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // First port
  input wire logic [7:0] first_port_pins_i,
  output logic [7:0] first_port_pins_o,
  output logic [7:0] first_port_pins_oe_o,
  output logic [7:0] first_port_pins_pu_o,
  // Second port
  input wire logic [7:0] second_port_pins_i,
  output logic [7:0] second_port_pins_o,
  output logic [7:0] second_port_pins_oe_o,
  output logic [7:0] second_port_pins_pu_o,
  // Third port
  input wire logic [7:0] third_port_pins_i,
  output logic [7:0] third_port_pins_o,
  output logic [7:0] third_port_pins_oe_o,
  output logic [7:0] third_port_pins_pu_o,
  // Fourth port
  input wire logic [7:0] fourth_port_pins_i,
  output logic [7:0] fourth_port_pins_o,
  output logic [7:0] fourth_port_pins_oe_o,
  output logic [7:0] fourth_port_pins_pu_o,
  // Fifth port
  input wire logic [7:0] fifth_port_pins_i,
  output logic [7:0] fifth_port_pins_o,
  output logic [7:0] fifth_port_pins_oe_o,
  output logic [7:0] fifth_port_pins_pu_o,
  // Sixth port
  input wire logic [7:0] sixth_port_pins_i,
  output logic [7:0] sixth_port_pins_o,
  output logic [7:0] sixth_port_pins_oe_o,
  output logic [7:0] sixth_port_pins_pu_o,
  // Short port
  input wire logic [4:0] short_port_pins_i,
  output logic [4:0] short_port_pins_o,
  output logic [4:0] short_port_pins_oe_o,
  output logic [4:0] short_port_pins_pu_o,
  // Test access port and memory strobes
  input wire logic tap_shift_i,
  input wire logic tap_tdo_i,
  input wire logic [2:0] mem_strobe_i,
  // Programming enable
  input wire logic programming_enable_pin_i,
  output logic programming_enable_pin_pu_o,
  output logic prog_mode_o
);
  logic rst_any_n;
  logic [7:0] pin_raw [PORT_CNT];
  logic [7:0] pin_sync [PORT_CNT];
  logic [7:0] out_r [PORT_CNT];
  logic [7:0] out_nxt [PORT_CNT];
  logic [7:0] dir_r [PORT_CNT];
  logic [7:0] dir_nxt [PORT_CNT];
  logic [7:0] pull_r [PORT_CNT];
  logic [7:0] pull_nxt [PORT_CNT];
  logic [7:0] oe_q [PORT_CNT];
  logic [7:0] out_q [PORT_CNT];
  logic [7:0] pu_q [PORT_CNT];
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [2:0] sel_port;
  logic [7:0] mask;
  logic pen_s;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic prog_r;
  logic prog_nxt;
  logic pen_pu_r;
  logic legacy;
  logic jtag_on;
  logic conv_on;

  // Either the pin or power-on holds the port logic and bus slave in reset
  assign rst_any_n = rstn_i & por_n_i;
  assign legacy = ctrl_r[CTRL_LEGACY];
  assign jtag_on = ctrl_r[CTRL_JTAG];
  assign conv_on = ctrl_r[CTRL_CONV];

  assign pin_raw[0] = first_port_pins_i;
  assign pin_raw[1] = second_port_pins_i;
  assign pin_raw[2] = third_port_pins_i;
  assign pin_raw[3] = fourth_port_pins_i;
  assign pin_raw[4] = fifth_port_pins_i;
  assign pin_raw[5] = sixth_port_pins_i;
  assign pin_raw[6] = {3'h0, short_port_pins_i};

  // Register file and bus slave
  assign sel_port = wb_adr_i[6:4];
  assign mask = (sel_port == PORT_LAST) ? SHORT_MASK : 8'hff;

  always_comb begin
    out_nxt = out_r;
    dir_nxt = dir_r;
    pull_nxt = pull_r;
    ctrl_nxt = ctrl_r;
    ack_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (wb_cyc_i && wb_stb_i && !ack_r) begin
      ack_nxt = 1'b1;
      rdata_nxt = '0;
      if (!wb_adr_i[7] && sel_port <= PORT_LAST && wb_adr_i[1:0] == 2'h0) begin
        unique case ({4'h0, wb_adr_i[3:0]})
          OFS_OUT: begin
            rdata_nxt[7:0] = out_r[sel_port];
            if (wb_we_i && wb_sel_i[0]) begin
              out_nxt[sel_port] = wb_dat_i[7:0] & mask;
            end
          end
          OFS_DIR: begin
            rdata_nxt[7:0] = dir_r[sel_port];
            if (wb_we_i && wb_sel_i[0]) begin
              dir_nxt[sel_port] = wb_dat_i[7:0] & mask;
            end
          end
          OFS_PULL: begin
            rdata_nxt[7:0] = pull_r[sel_port];
            if (wb_we_i && wb_sel_i[0]) begin
              pull_nxt[sel_port] = wb_dat_i[7:0] & mask;
            end
          end
          default: begin
            rdata_nxt[7:0] = pin_sync[sel_port] & mask;
          end
        endcase
      end else if (wb_adr_i == CTRL_ADDR) begin
        rdata_nxt[2:0] = ctrl_r;
        if (wb_we_i && wb_sel_i[0]) begin
          ctrl_nxt = wb_dat_i[2:0];
        end
      end else if (wb_adr_i == STAT_ADDR) begin
        rdata_nxt[1:0] = {prog_r, tap_shift_i};
      end
    end
  end

  // Port registers clear on any reset, so pins start as plain inputs unless a set mode bit claims them
  always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      out_r <= '{default: 8'h00};
      dir_r <= '{default: 8'h00};
      pull_r <= '{default: 8'h00};
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      out_r <= out_nxt;
      dir_r <= dir_nxt;
      pull_r <= pull_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Mode bits behave like fuses: only power-on restores them
  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign wb_dat_o = rdata_r;
  assign wb_ack_o = ack_r;

  // Per-pin drive logic
  genvar p;
  genvar b;
  generate
    for (p = 0; p < PORT_CNT; p++) begin : g_port
      sync2 #(.WIDTH(8), .RST_VAL(1'b0)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_any_n),
        .d_i(pin_raw[p]),
        .q_o(pin_sync[p])
      );
      for (b = 0; b < PORT_W; b++) begin : g_bit
        if (p != SHORT_PORT || b < SHORT_W) begin : g_live
          localparam bit IS_THIRD = (p == THIRD_PORT);
          localparam bit IS_SIXTH = (p == SIXTH_PORT);
          localparam bit IS_STROBE = (p == SHORT_PORT) && (b < STROBE_CNT);
          localparam bit IS_OSC = (p == SHORT_PORT) && (b >= STROBE_CNT);
          localparam bit IS_SCAN_IN = IS_SIXTH && (b == TDI_BIT || b == TMS_BIT ||
                                                  b == TCK_BIT);
          localparam bit IS_TDO = IS_SIXTH && (b == TDO_BIT);
          localparam logic ALT_OUT = IS_STROBE ? SHORT_LEG_RST[b] : 1'b0;
          logic oe_n;
          logic out_n;
          logic pu_n;
          logic alt;
          logic strobe;

          if (IS_STROBE) begin : g_strobe
            assign strobe = mem_strobe_i[b];
          end else begin : g_nostrobe
            assign strobe = 1'b0;
          end

          // Pins whose reset must not simply float them
          assign alt = ((IS_THIRD || IS_STROBE) && legacy) || (IS_SCAN_IN && jtag_on);

          always_comb begin
            oe_n = dir_r[p][b];
            out_n = out_r[p][b];
            pu_n = pull_r[p][b] & ~dir_r[p][b];
            if (IS_THIRD && legacy) begin
              oe_n = 1'b1;
              pu_n = 1'b0;
            end
            if (IS_SIXTH && (legacy || conv_on)) begin
              oe_n = 1'b0;
              if (conv_on) begin
                pu_n = 1'b0;
              end
            end
            if (IS_SCAN_IN && jtag_on) begin
              oe_n = 1'b0;
              pu_n = 1'b1;
            end
            if (IS_TDO && jtag_on) begin
              oe_n = tap_shift_i;
              out_n = tap_tdo_i;
              pu_n = 1'b0;
            end
            if (IS_STROBE && legacy) begin
              oe_n = 1'b1;
              out_n = strobe;
              pu_n = 1'b0;
            end
            if (IS_OSC && legacy) begin
              // Oscillator pins: the logic keeps its hands off
              oe_n = 1'b0;
              pu_n = 1'b0;
            end
          end

          pin_cell #(.ALT_OE(IS_THIRD || IS_STROBE), .ALT_OUT(ALT_OUT),
                     .ALT_PU(IS_SCAN_IN)) u_cell (
            .ref_clk_i(ref_clk_i),
            .rst_plain_n_i(rst_any_n | alt),
            .rst_alt_n_i(rst_any_n | ~alt),
            .oe_nxt_i(oe_n),
            .out_nxt_i(out_n),
            .pu_nxt_i(pu_n),
            .oe_o(oe_q[p][b]),
            .out_o(out_q[p][b]),
            .pu_o(pu_q[p][b])
          );
        end else begin : g_absent
          assign oe_q[p][b] = 1'b0;
          assign out_q[p][b] = 1'b0;
          assign pu_q[p][b] = 1'b0;
        end
      end
    end
  endgenerate

  assign first_port_pins_o = out_q[0];
  assign first_port_pins_oe_o = oe_q[0];
  assign first_port_pins_pu_o = pu_q[0];
  assign second_port_pins_o = out_q[1];
  assign second_port_pins_oe_o = oe_q[1];
  assign second_port_pins_pu_o = pu_q[1];
  assign third_port_pins_o = out_q[2];
  assign third_port_pins_oe_o = oe_q[2];
  assign third_port_pins_pu_o = pu_q[2];
  assign fourth_port_pins_o = out_q[3];
  assign fourth_port_pins_oe_o = oe_q[3];
  assign fourth_port_pins_pu_o = pu_q[3];
  assign fifth_port_pins_o = out_q[4];
  assign fifth_port_pins_oe_o = oe_q[4];
  assign fifth_port_pins_pu_o = pu_q[4];
  assign sixth_port_pins_o = out_q[5];
  assign sixth_port_pins_oe_o = oe_q[5];
  assign sixth_port_pins_pu_o = pu_q[5];
  assign short_port_pins_o = out_q[6][4:0];
  assign short_port_pins_oe_o = oe_q[6][4:0];
  assign short_port_pins_pu_o = pu_q[6][4:0];

  // Programming enable, taken once after power-on
  sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_pen_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(por_n_i),
    .d_i(programming_enable_pin_i),
    .q_o(pen_s)
  );

  always_comb begin
    settle_nxt = settle_r;
    prog_nxt = prog_r;
    if (settle_r != PEN_SETTLE) begin
      settle_nxt = settle_r + 2'h1;
      if (settle_r == PEN_SETTLE - 2'h1) begin
        prog_nxt = ~pen_s;
      end
    end
  end

  // The pin reset does not reach here, so the choice survives it
  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      settle_r <= 2'h0;
      prog_r <= 1'b0;
      pen_pu_r <= 1'b1;
    end else begin
      settle_r <= settle_nxt;
      prog_r <= prog_nxt;
      pen_pu_r <= 1'b1;
    end
  end

  assign prog_mode_o = prog_r;
  assign programming_enable_pin_pu_o = pen_pu_r;

  reset_floats_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    !rstn_i |-> first_port_pins_oe_o == 8'h00 && fifth_port_pins_oe_o == 8'h00)
    else $error("port drives during reset");
  third_drives_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    legacy && $past(legacy) |-> third_port_pins_oe_o == 8'hff)
    else $error("third port not driving in legacy mode");
  sixth_input_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    legacy && $past(legacy) && !jtag_on && !$past(jtag_on) |-> sixth_port_pins_oe_o == 8'h00)
    else $error("sixth port drives in legacy mode");
  conv_input_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    conv_on && !jtag_on |=> sixth_port_pins_oe_o == 8'h00)
    else $error("sixth port drives while converter on");
  scan_pullup_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    jtag_on && $past(jtag_on) |-> sixth_port_pins_pu_o[7] && sixth_port_pins_pu_o[5]
      && sixth_port_pins_pu_o[4])
    else $error("scan pull-up dropped");
  tdo_float_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    rst_any_n && $past(rst_any_n) && $past(jtag_on)
      |-> sixth_port_pins_oe_o[6] == $past(tap_shift_i))
    else $error("scan output drive wrong");
  strobe_reset_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    !rstn_i && legacy |-> short_port_pins_o[2:0] == 3'h3 && short_port_pins_oe_o[2:0] == 3'h7)
    else $error("strobe reset values wrong");
  prog_hold_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    settle_r == PEN_SETTLE && $past(settle_r) == PEN_SETTLE |-> $stable(prog_mode_o))
    else $error("programming mode changed after sampling");
  dir_cleared_a: assert property (@(posedge ref_clk_i) disable iff (!por_n_i)
    $rose(rst_any_n) |-> dir_r[0] == 8'h00 && out_r[3] == 8'h00 && pull_r[6] == 8'h00)
    else $error("port registers not cleared by reset");
  bus_ack_a: assert property (@(posedge ref_clk_i) disable iff (!rst_any_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");
endmodule

// file: verif/board_model.sv
// Board-side model of the port pins: device drive, board drivers and pull-ups
module board_model #(
  parameter int W = 8
) (
  input wire logic ref_clk_i,
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pu_i,
  input wire logic [W-1:0] ext_i,
  input wire logic [W-1:0] ext_en_i,
  output logic [W-1:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Floating pins wander each cycle so a stale level never passes
  logic [W-1:0] flt_r = '0;
  always @(posedge ref_clk_i) begin
    flt_r <= ~flt_r;
  end
  // Device drive wins, then the board, then the pull-up
  always_comb begin
    for (int b = 0; b < W; b++) begin
      lvl_o[b] = oe_i[b] ? drv_i[b] : ext_en_i[b] ? ext_i[b] : pu_i[b] ? 1'b1 : flt_r[b];
    end
  end
endmodule

// file: verif/tb.sv
// Self-checking bench for the general-purpose port block
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_pkg::*;
  logic ref_clk_i = 1'b0;
  logic run = 1'b1;
  logic rstn_i, por_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tap_shift_i, tap_tdo_i;
  logic programming_enable_pin_pu_o, prog_mode_o, pen_lvl, pen_low;
  logic [7:0] wb_adr_i, m, vo, vd, vp;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [2:0] mem_strobe_i;
  logic [7:0] po [7], poe [7], ppu [7], pin [7], ext [7], exen [7];
  int n_fail = 0;
  int check_count = 0;
  int cyc_cnt = 0;
  int seed = 32'hd084649c;

  always #4 begin
    if (run) ref_clk_i = ~ref_clk_i;
  end

  port_pin_reset_behaviour uut (.ref_clk_i, .rstn_i, .por_n_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .first_port_pins_i(pin[0]), .first_port_pins_o(po[0]),
    .first_port_pins_oe_o(poe[0]), .first_port_pins_pu_o(ppu[0]),
    .second_port_pins_i(pin[1]), .second_port_pins_o(po[1]),
    .second_port_pins_oe_o(poe[1]), .second_port_pins_pu_o(ppu[1]),
    .third_port_pins_i(pin[2]), .third_port_pins_o(po[2]),
    .third_port_pins_oe_o(poe[2]), .third_port_pins_pu_o(ppu[2]),
    .fourth_port_pins_i(pin[3]), .fourth_port_pins_o(po[3]),
    .fourth_port_pins_oe_o(poe[3]), .fourth_port_pins_pu_o(ppu[3]),
    .fifth_port_pins_i(pin[4]), .fifth_port_pins_o(po[4]),
    .fifth_port_pins_oe_o(poe[4]), .fifth_port_pins_pu_o(ppu[4]),
    .sixth_port_pins_i(pin[5]), .sixth_port_pins_o(po[5]),
    .sixth_port_pins_oe_o(poe[5]), .sixth_port_pins_pu_o(ppu[5]),
    .short_port_pins_i(pin[6][4:0]), .short_port_pins_o(po[6][4:0]),
    .short_port_pins_oe_o(poe[6][4:0]), .short_port_pins_pu_o(ppu[6][4:0]),
    .tap_shift_i, .tap_tdo_i, .mem_strobe_i, .programming_enable_pin_i(pen_lvl),
    .programming_enable_pin_pu_o, .prog_mode_o);

  for (genvar g = 0; g < 7; g++) begin : g_bd
    board_model bm (.ref_clk_i, .drv_i(po[g]), .oe_i(poe[g]), .pu_i(ppu[g]),
      .ext_i(ext[g]), .ext_en_i(exen[g]), .lvl_o(pin[g]));
  end
  board_model #(.W(1)) pm (.ref_clk_i, .drv_i(1'b0), .oe_i(1'b0),
    .pu_i(programming_enable_pin_pu_o), .ext_i(1'b0), .ext_en_i(pen_low), .lvl_o(pen_lvl));

  function automatic logic [7:0] adr(input int p, input logic [7:0] ofs);
    return 8'(p) * PORT_STRIDE + ofs;
  endfunction

  // Level read back: own drive, else board drive, else pull-up
  function automatic logic [7:0] exp_pin(input logic [7:0] o, d, p, e, en);
    return (d & o) | (~d & en & e) | (~d & ~en & p);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= d;
    // No own limit: a missing answer is caught by the hang guard
    do begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    rstn_i = 1'b0;
    por_n_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, tap_shift_i, tap_tdo_i} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    mem_strobe_i = 3'h5;
    pen_low = 1'b1;
    for (int p = 0; p < 7; p++) begin
      ext[p] = 8'h00;
      exen[p] = 8'h00;
    end
    tick(2);
    `CHK("third oe in por", 8'hff, poe[2]);
    `CHK("third out in por", 8'h00, po[2]);
    `CHK("short oe in por", 5'h07, poe[6][4:0]);
    `CHK("short out in por", 3'h3, po[6][2:0]);
    `CHK("scan pulls in por", 8'hb0, ppu[5] & 8'hb0);
    `CHK("first oe in por", 8'h00, poe[0]);
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    por_n_i <= 1'b1;
    tick(6);
    `CHK("prog mode", 1'b1, prog_mode_o);
    `CHK("enable pull", 1'b1, programming_enable_pin_pu_o);
    pen_low <= 1'b0;
    wb(0, CTRL_ADDR, 0);
    `CHK("ctrl reset", CTRL_RST, rd);
    tick(2);
    `CHK("strobes", mem_strobe_i, po[6][2:0]);
    `CHK("short oe legacy", 5'h07, poe[6][4:0]);
    `CHK("sixth oe legacy", 8'h00, poe[5]);
    `CHK("third oe legacy", 8'hff, poe[2]);
    $display("test power-on finished");

    wb(1, CTRL_ADDR, 0);
    for (int p = 0; p < 7; p++) begin
      m = (p == SHORT_PORT) ? SHORT_MASK : 8'hff;
      vo = 8'($random(seed));
      vd = 8'($random(seed));
      vp = 8'($random(seed));
      ext[p] <= 8'($random(seed));
      exen[p] <= 8'($random(seed));
      wb(1, adr(p, OFS_OUT), {24'h0, vo});
      wb(1, adr(p, OFS_DIR), {24'h0, vd});
      wb(1, adr(p, OFS_PULL), {24'h0, vp});
      wb(0, adr(p, OFS_DIR), 0);
      `CHK("dir readback", vd & m, rd);
      tick(3);
      `CHK("oe", vd & m, poe[p] & m);
      `CHK("out", vo & m, po[p] & m);
      `CHK("pull", vp & ~vd & m, ppu[p] & m);
      wb(0, adr(p, OFS_PIN), 0);
      m = m & (vd | exen[p] | vp);
      `CHK("pin", exp_pin(vo, vd, vp, ext[p], exen[p]) & m, rd[7:0] & m);
    end
    wb(0, 8'h70, 0);
    `CHK("unmapped", 0, rd);
    $display("test ports finished");

    wb(1, CTRL_ADDR, 32'h2);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i);
      tap_shift_i <= 1'($random(seed));
      tap_tdo_i <= 1'($random(seed));
      tick(1);
      `CHK("tdo oe", tap_shift_i, poe[5][TDO_BIT]);
      `CHK("tdo", tap_tdo_i, po[5][TDO_BIT]);
    end
    `CHK("scan pulls", 8'hb0, ppu[5] & 8'hb0);
    // Clock held still: the float must come from reset alone
    @(negedge ref_clk_i);
    run = 1'b0;
    rstn_i = 1'b0;
    #2;
    for (int p = 0; p < 7; p++) begin
      m = (p == SHORT_PORT) ? SHORT_MASK : 8'hff;
      `CHK("float", 8'h00, poe[p] & m);
      `CHK("pulls in reset", (p == SIXTH_PORT) ? 8'hb0 : 8'h00, ppu[p] & m);
    end
    run = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    wb(0, adr(0, OFS_DIR), 0);
    `CHK("dir cleared", 0, rd);
    wb(0, CTRL_ADDR, 0);
    `CHK("ctrl kept", 32'h2, rd);
    $display("test scan and reset finished");

    wb(1, CTRL_ADDR, 32'h4);
    wb(1, adr(5, OFS_DIR), 32'hff);
    wb(1, adr(5, OFS_PULL), 32'hff);
    tick(3);
    `CHK("conv oe", 8'h00, poe[5]);
    `CHK("conv pull", 8'h00, ppu[5]);
    wb(1, CTRL_ADDR, 0);
    tick(3);
    `CHK("sixth general", 8'hff, poe[5]);
    $display("test converter finished");

    @(posedge ref_clk_i);
    mem_strobe_i <= 3'($random(seed));
    wb(1, CTRL_ADDR, 32'h1);
    wb(1, adr(2, OFS_DIR), 0);
    tick(3);
    `CHK("third drives", 8'hff, poe[2]);
    `CHK("sixth input", 8'h00, poe[5]);
    `CHK("strobe follow", mem_strobe_i, po[6][2:0]);
    `CHK("osc float", 2'h0, poe[6][4:3]);
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    tick(1);
    `CHK("third in reset", 8'hff, poe[2]);
    `CHK("third out reset", 8'h00, po[2]);
    `CHK("strobe reset", 3'h3, po[6][2:0]);
    `CHK("first float", 8'h00, poe[0]);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    wb(0, STAT_ADDR, 0);
    `CHK("prog held", 1'b1, rd[1]);
    $display("test legacy finished");
    give_verdict();
  end
endmodule
